// ==== disp_pkg.sv ====
package disp_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int DIGITS = 6;
  localparam int CW = 27;
  localparam int ERRS = 8;
  localparam int LONG_MS = 4000;
  localparam int TIMEOUT_MS = 10000;
  localparam int ENERGY_SHOW_MS = 6000;
  localparam int ERR_SHOW_MS = 2000;
  localparam int TEST_MS = 3000;
  localparam int ARROW_MS = 500;
  localparam int ANIM_STEP_MS = 250;
  localparam int COMM_HOLD_MS = 200;
  localparam int DENY_MS = 2000;
  localparam int DEB_MS = 10;
  localparam int LED_MS = 40;
  localparam int S0_MS = 100;
  localparam int LED_IMP_KWH = 1000;
  localparam int S0_IMP_KWH = 100;
  localparam int S0_DIV = LED_IMP_KWH / S0_IMP_KWH;
  localparam int LONG_CYC = LONG_MS * CYC_PER_MS;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * CYC_PER_MS;
  localparam int ENERGY_CYC = ENERGY_SHOW_MS * CYC_PER_MS;
  localparam int ERR_CYC = ERR_SHOW_MS * CYC_PER_MS;
  localparam int TEST_CYC = TEST_MS * CYC_PER_MS;
  localparam int ARROW_CYC = ARROW_MS * CYC_PER_MS;
  localparam int ANIM_CYC = ANIM_STEP_MS * CYC_PER_MS;
  localparam int COMM_CYC = COMM_HOLD_MS * CYC_PER_MS;
  localparam int DENY_CYC = DENY_MS * CYC_PER_MS;
  localparam int DEB_CYC = DEB_MS * CYC_PER_MS;
  localparam int LED_CYC = LED_MS * CYC_PER_MS;
  localparam int S0_CYC = S0_MS * CYC_PER_MS;
  localparam logic [6:0] SEG_BLANK = 7'h00;
  localparam logic [6:0] SEG_FULL = 7'h7f;
  localparam logic [2:0] ARROW_ALL = 3'h7;
  localparam logic [2:0] ARROW_FIRST = 3'h1;
  localparam logic [3:0] ERR_NONE = 4'h8;

  typedef enum logic [1:0] {ST_TEST, ST_NORMAL, ST_ALT, ST_ANIM} mode_t;

  typedef struct packed {
    logic [DIGITS-1:0][6:0] digit;
    logic                   tri_on;
    logic [2:0]             arrow;
    logic                   rx;
    logic                   tx;
    logic                   deny;
  } lcd_t;

  typedef struct packed {
    mode_t         mode;
    logic [CW-1:0] tmr;
    logic [CW-1:0] idle;
    logic [CW-1:0] press;
    logic [CW-1:0] deb;
    logic [CW-1:0] arrow_t;
    logic [CW-1:0] rx_t;
    logic [CW-1:0] deny_t;
    logic          btn;
    logic          held_long;
    logic          show_err;
    logic [3:0]    err_idx;
    logic [2:0]    anim_pos;
    logic          clr;
    lcd_t          lcd;
  } ctrl_t;

  typedef struct packed {
    logic [3:0]    div;
    logic [3:0]    pend;
    logic [CW-1:0] len;
    logic          out;
  } pulse_t;

  localparam ctrl_t CTRL_RST = '0;
  localparam pulse_t PULSE_RST = '0;

  function automatic logic [6:0] bcd_seg(input logic [3:0] d);
    logic [6:0] r;
    r = SEG_BLANK;
    case (d)
      4'h0: r = 7'h3f;
      4'h1: r = 7'h06;
      4'h2: r = 7'h5b;
      4'h3: r = 7'h4f;
      4'h4: r = 7'h66;
      4'h5: r = 7'h6d;
      4'h6: r = 7'h7d;
      4'h7: r = 7'h07;
      4'h8: r = 7'h7f;
      4'h9: r = 7'h6f;
      default: r = SEG_BLANK;
    endcase
    return r;
  endfunction
endpackage

// ==== energy_pulse_out.sv ====
// Turns energy ticks into stretched pulses; ticks that arrive during a pulse wait in a count
module energy_pulse_out #(
  parameter int DIV = 1,
  parameter int LEN = 400000
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic tick,
  output logic      pulse
);
  disp_pkg::pulse_t s;
  disp_pkg::pulse_t n;

  always_comb begin
    n = s;
    if (tick) begin
      if (s.div == 4'(DIV - 1)) begin
        n.div = 4'h0;
        if (s.pend != 4'hf) n.pend = s.pend + 4'h1;
      end else begin
        n.div = s.div + 4'h1;
      end
    end
    if (s.out) begin
      if (s.len == disp_pkg::CW'(LEN - 1)) begin
        n.out = 1'b0;
        n.len = '0;
      end else begin
        n.len = s.len + 1'b1;
      end
    end else if (s.pend != 4'h0) begin
      n.out = 1'b1;
      n.len = '0;
      n.pend = n.pend - 4'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) s <= disp_pkg::PULSE_RST;
    else s <= n;
  end

  assign pulse = s.out;
endmodule

// ==== meter_display_ctrl.sv ====
// Behaviour
// - Short press in Normal mode enters Alternative mode showing resettable energy.
// - Press held to the threshold clears the resettable energy.
// - After a reset a single zero steps from leftmost to rightmost digit.
// - After the moving zero the display enters Alternative mode showing zeros.
// - No press for the timeout returns the display to Normal mode.
// - With errors, show energy six seconds then each code two seconds.
// - After the last code the cycle restarts with energy while errors remain.
// - Normal shows total energy, Alternative resettable energy, whole kWh.
// - Mode triangle off in Normal, steadily on in Alternative.
// - At power-up all segments light for a few seconds, then Normal.
// - Without the reset option, Alternative mode is never entered.
// - Above start current arrows rotate at fixed rate, else all steady on.
// - Arrows rotate forward for positive energy, backward for negative.
// - A valid message addressed to the meter lights the receive segment.
// - The transmit segment is lit while transmitting.
// - Forbidden operations, such as disabled local reset, light the deny symbol.
// - Measurement, register updates and pulses continue in every mode.
// - The front LED flashes once per fixed energy quantum.
// - The isolated output gives a fixed number of pulses per kWh.
// - Energy is rendered on six seven-segment digits.
// - LED rate is 1000 flashes per kWh, each 40 ms long.
module meter_display_ctrl #(
  parameter int LONG_C    = disp_pkg::LONG_CYC,
  parameter int TIMEOUT_C = disp_pkg::TIMEOUT_CYC,
  parameter int ENERGY_C  = disp_pkg::ENERGY_CYC,
  parameter int ERR_C     = disp_pkg::ERR_CYC,
  parameter int TEST_C    = disp_pkg::TEST_CYC,
  parameter int ARROW_C   = disp_pkg::ARROW_CYC,
  parameter int ANIM_C    = disp_pkg::ANIM_CYC,
  parameter int COMM_C    = disp_pkg::COMM_CYC,
  parameter int DENY_C    = disp_pkg::DENY_CYC,
  parameter int DEB_C     = disp_pkg::DEB_CYC,
  parameter int LED_C     = disp_pkg::LED_CYC,
  parameter int S0_C      = disp_pkg::S0_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 button,
  input  wire logic                 has_reset_opt,
  input  wire logic                 local_reset_en,
  input  wire logic [23:0]          total_bcd,
  input  wire logic [23:0]          reset_bcd,
  input  wire logic [7:0]           err_mask,
  input  wire logic                 above_start,
  input  wire logic                 energy_neg,
  input  wire logic                 rx_msg,
  input  wire logic                 tx_active,
  input  wire logic                 energy_tick,
  output disp_pkg::lcd_t            lcd,
  output logic                      energy_clear,
  output logic                      led,
  output logic                      pulse_out
);
  disp_pkg::ctrl_t s;
  disp_pkg::ctrl_t n;
  logic            rise;
  logic            fall;
  logic            long_hit;
  logic [3:0]      nxt;
  logic [23:0]     bcd;

  function automatic logic [3:0] first_from(input logic [7:0] m, input logic [3:0] from);
    logic [3:0] r;
    r = disp_pkg::ERR_NONE;
    for (int i = disp_pkg::ERRS - 1; i >= 0; i--) begin
      if (m[i] && 4'(i) >= from) r = 4'(i);
    end
    return r;
  endfunction

  always_comb begin
    n = s;
    n.clr = 1'b0;
    nxt = disp_pkg::ERR_NONE;
    bcd = total_bcd;
    if (button != s.btn) begin
      if (s.deb == disp_pkg::CW'(DEB_C - 1)) begin
        n.btn = button;
        n.deb = '0;
      end else begin
        n.deb = s.deb + 1'b1;
      end
    end else begin
      n.deb = '0;
    end
    rise = n.btn & ~s.btn;
    fall = ~n.btn & s.btn;
    // Reaching the threshold counts as long
    long_hit = s.btn && !s.held_long && s.press == disp_pkg::CW'(LONG_C - 1);
    if (rise) begin
      n.press = '0;
      n.held_long = 1'b0;
    end else if (s.btn && !s.held_long) begin
      n.press = s.press + 1'b1;
    end
    if (long_hit) n.held_long = 1'b1;
    if (rise || s.btn) n.idle = '0;
    else if (s.idle != disp_pkg::CW'(TIMEOUT_C)) n.idle = s.idle + 1'b1;
    if (s.deny_t != '0) n.deny_t = s.deny_t - 1'b1;

    case (s.mode)
      disp_pkg::ST_TEST: begin
        n.tmr = s.tmr + 1'b1;
        if (s.tmr == disp_pkg::CW'(TEST_C - 1)) begin
          n.mode = disp_pkg::ST_NORMAL;
          n.tmr = '0;
          n.show_err = 1'b0;
        end
      end
      disp_pkg::ST_NORMAL, disp_pkg::ST_ALT: begin
        if (long_hit && has_reset_opt && local_reset_en) begin
          n.clr = 1'b1;
          n.mode = disp_pkg::ST_ANIM;
          n.anim_pos = '0;
          n.tmr = '0;
        end else if (long_hit) begin
          n.deny_t = disp_pkg::CW'(DENY_C);
        end else if (fall && !s.held_long && s.mode == disp_pkg::ST_NORMAL && has_reset_opt) begin
          n.mode = disp_pkg::ST_ALT;
        end else if (s.mode == disp_pkg::ST_ALT &&
                     (!has_reset_opt || s.idle == disp_pkg::CW'(TIMEOUT_C - 1))) begin
          n.mode = disp_pkg::ST_NORMAL;
          n.tmr = '0;
          n.show_err = 1'b0;
        end else if (s.mode == disp_pkg::ST_NORMAL) begin
          if (err_mask == 8'h00) begin
            n.show_err = 1'b0;
            n.tmr = '0;
          end else if (!s.show_err && s.tmr == disp_pkg::CW'(ENERGY_C - 1)) begin
            n.show_err = 1'b1;
            n.err_idx = first_from(err_mask, 4'h0);
            n.tmr = '0;
          end else if (s.show_err && s.tmr == disp_pkg::CW'(ERR_C - 1)) begin
            nxt = first_from(err_mask, s.err_idx + 4'h1);
            n.tmr = '0;
            // Restart with energy after last code
            if (nxt == disp_pkg::ERR_NONE) n.show_err = 1'b0;
            else n.err_idx = nxt;
          end else begin
            n.tmr = s.tmr + 1'b1;
          end
        end
      end
      disp_pkg::ST_ANIM: begin
        n.tmr = s.tmr + 1'b1;
        if (s.tmr == disp_pkg::CW'(ANIM_C - 1)) begin
          n.tmr = '0;
          if (s.anim_pos == 3'(disp_pkg::DIGITS - 1)) begin
            n.mode = disp_pkg::ST_ALT;
            n.idle = '0;
          end else begin
            n.anim_pos = s.anim_pos + 3'h1;
          end
        end
      end
      default: n.mode = disp_pkg::ST_TEST;
    endcase

    // Fixed rate rotation or steady arrows
    if (!above_start) begin
      n.arrow_t = '0;
      n.lcd.arrow = disp_pkg::ARROW_ALL;
    end else if (s.lcd.arrow == disp_pkg::ARROW_ALL) begin
      n.arrow_t = '0;
      n.lcd.arrow = disp_pkg::ARROW_FIRST;
    end else if (s.arrow_t == disp_pkg::CW'(ARROW_C - 1)) begin
      n.arrow_t = '0;
      if (energy_neg) n.lcd.arrow = {s.lcd.arrow[0], s.lcd.arrow[2:1]};
      else n.lcd.arrow = {s.lcd.arrow[1:0], s.lcd.arrow[2]};
    end else begin
      n.arrow_t = s.arrow_t + 1'b1;
    end

    if (rx_msg) n.rx_t = disp_pkg::CW'(COMM_C);
    else if (s.rx_t != '0) n.rx_t = s.rx_t - 1'b1;
    n.lcd.rx = (n.rx_t != '0);
    n.lcd.tx = tx_active;
    n.lcd.deny = (n.deny_t != '0);
    n.lcd.tri_on = (n.mode == disp_pkg::ST_ALT);

    if (n.mode == disp_pkg::ST_ALT) bcd = reset_bcd;
    else if (n.show_err) bcd = {12'hfff, 4'(n.err_idx + 4'h1), 8'h00};
    for (int d = 0; d < disp_pkg::DIGITS; d++) begin
      if (n.mode == disp_pkg::ST_TEST) n.lcd.digit[d] = disp_pkg::SEG_FULL;
      else if (n.mode == disp_pkg::ST_ANIM)
        n.lcd.digit[d] = (3'(disp_pkg::DIGITS - 1 - d) == n.anim_pos) ?
                         disp_pkg::bcd_seg(4'h0) : disp_pkg::SEG_BLANK;
      else n.lcd.digit[d] = disp_pkg::bcd_seg(bcd[d*4 +: 4]);
    end
    if (n.mode == disp_pkg::ST_TEST) begin
      n.lcd.tri_on = 1'b1;
      n.lcd.arrow = disp_pkg::ARROW_ALL;
      n.lcd.rx = 1'b1;
      n.lcd.tx = 1'b1;
      n.lcd.deny = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) s <= disp_pkg::CTRL_RST;
    else s <= n;
  end

  assign lcd = s.lcd;
  assign energy_clear = s.clr;

  // Pulse paths run apart from display state
  energy_pulse_out #(.DIV(1), .LEN(LED_C)) u_led (
    .clk   (clk),
    .reset (reset),
    .tick  (energy_tick),
    .pulse (led)
  );

  energy_pulse_out #(.DIV(disp_pkg::S0_DIV), .LEN(S0_C)) u_s0 (
    .clk   (clk),
    .reset (reset),
    .tick  (energy_tick),
    .pulse (pulse_out)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_SHORT_ALT: assert property (s.mode == disp_pkg::ST_NORMAL && has_reset_opt && !long_hit && fall && !s.held_long |=> s.mode == disp_pkg::ST_ALT && s.lcd.tri_on) else $error("short press did not enter alternative");
  AST_LONG_CLR: assert property (long_hit && s.mode != disp_pkg::ST_TEST && s.mode != disp_pkg::ST_ANIM && has_reset_opt && local_reset_en |=> energy_clear && s.mode == disp_pkg::ST_ANIM && s.anim_pos == 3'h0) else $error("long press did not clear energy");
  AST_ANIM_ONE: assert property (s.mode == disp_pkg::ST_ANIM |->
    $countones(s.lcd.digit) == $countones(disp_pkg::bcd_seg(4'h0)) &&
    s.lcd.digit[disp_pkg::DIGITS - 1 - int'(s.anim_pos)] == disp_pkg::bcd_seg(4'h0))
    else $error("moving zero not shown");
  AST_ANIM_END: assert property (s.mode == disp_pkg::ST_ANIM && s.anim_pos == 3'(disp_pkg::DIGITS - 1) && s.tmr == disp_pkg::CW'(ANIM_C - 1) |=> s.mode == disp_pkg::ST_ALT) else $error("animation did not end in alternative");
  AST_TIMEOUT: assert property (s.mode == disp_pkg::ST_ALT && !long_hit && !fall && s.idle == disp_pkg::CW'(TIMEOUT_C - 1) |=> s.mode == disp_pkg::ST_NORMAL) else $error("timeout did not return to normal");
  AST_TRI: assert property ((s.mode == disp_pkg::ST_NORMAL |-> !s.lcd.tri_on) and (s.mode == disp_pkg::ST_ALT |-> s.lcd.tri_on)) else $error("triangle does not match mode");
  AST_NO_ALT: assert property (!has_reset_opt && s.mode == disp_pkg::ST_NORMAL |=> s.mode != disp_pkg::ST_ALT) else $error("alternative entered without option");
  AST_ARROW_STEADY: assert property (!above_start |=> s.lcd.arrow == disp_pkg::ARROW_ALL) else $error("arrows not steady below start");
  AST_ARROW_DIR: assert property (above_start && !energy_neg && s.lcd.arrow == 3'h1 && s.arrow_t == disp_pkg::CW'(ARROW_C - 1) |=> s.lcd.arrow == 3'h2) else $error("forward rotation wrong");
  AST_RX: assert property (rx_msg |=> s.lcd.rx [*2]) else $error("receive segment not lit");
  AST_DENY: assert property (long_hit && s.mode == disp_pkg::ST_NORMAL && !local_reset_en |=> s.lcd.deny && !energy_clear) else $error("refused reset not denied");

  // Lamp test, error cycling, link segments, arrow start and LED flashes
  AST_LAMP: assert property (
    s.mode == disp_pkg::ST_TEST && s.tmr != '0
    |-> s.lcd.digit == {disp_pkg::DIGITS{disp_pkg::SEG_FULL}} && s.lcd.deny)
    else $error("lamp test not lit");
  AST_LAMP_END: assert property (
    s.mode == disp_pkg::ST_TEST && s.tmr == disp_pkg::CW'(TEST_C - 1)
    |=> s.mode == disp_pkg::ST_NORMAL)
    else $error("lamp test did not end in normal");
  AST_ERR_FIRST: assert property (
    s.mode == disp_pkg::ST_NORMAL && !s.show_err && err_mask != 8'h00 && !long_hit && !fall &&
    s.tmr == disp_pkg::CW'(ENERGY_C - 1) |=> s.show_err)
    else $error("error code not shown after energy");
  AST_ERR_WRAP: assert property (
    s.mode == disp_pkg::ST_NORMAL && s.show_err && !long_hit && !fall && err_mask != 8'h00 &&
    s.tmr == disp_pkg::CW'(ERR_C - 1) &&
    first_from(err_mask, s.err_idx + 4'h1) == disp_pkg::ERR_NONE |=> !s.show_err)
    else $error("cycle did not restart with energy");
  AST_TX_OFF: assert property (
    !tx_active && n.mode != disp_pkg::ST_TEST
    |=> !s.lcd.tx)
    else $error("transmit segment lit while idle");
  AST_RX_END: assert property (
    s.rx_t == disp_pkg::CW'(1) && !rx_msg && n.mode != disp_pkg::ST_TEST
    |=> !s.lcd.rx)
    else $error("receive segment not cleared");
  AST_ARROW_ROT: assert property (
    above_start && n.mode != disp_pkg::ST_TEST && s.lcd.arrow == disp_pkg::ARROW_ALL
    |=> s.lcd.arrow == disp_pkg::ARROW_FIRST)
    else $error("rotation did not start");
  AST_LED_START: assert property (
    !led && energy_tick
    |-> ##2 led)
    else $error("flash not started for energy tick");
  AST_LED_LEN: assert property (
    $rose(led)
    |-> led [*4])
    else $error("flash too short");

  COV_ALT: cover property (s.mode == disp_pkg::ST_NORMAL ##1 s.mode == disp_pkg::ST_ALT);
  COV_RESET: cover property (energy_clear ##1 s.mode == disp_pkg::ST_ANIM);
  COV_ERR: cover property (s.show_err ##1 !s.show_err);
  COV_ROTATE: cover property (above_start && s.lcd.arrow == 3'h4);
endmodule

// ==== user_panel.sv ====
// Stands in for the user at the push button
module user_panel (
  input  wire logic clk,
  output logic      button
);
  timeunit 1ns;
  timeprecision 1ns;
  initial button = 1'b0;
  // Holds the button for n edges, let go just after an edge
  task automatic press(input int n);
    button = 1'b1;
    repeat (n) @(posedge clk);
    #10;
    button = 1'b0;
  endtask
endmodule

// ==== tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LONG_C = 40;
  localparam int TIMEOUT_C = 100;
  localparam int ENERGY_C = 60;
  localparam int ERR_C = 20;
  localparam int TEST_C = 30;
  localparam int ARROW_C = 5;
  localparam int ANIM_C = 4;
  localparam int COMM_C = 8;
  localparam int DENY_C = 10;
  localparam int DEB_C = 2;
  localparam int LED_C = 4;
  localparam int S0_C = 6;
  localparam logic [6:0] SEGS [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
                                      7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  typedef struct {logic [23:0] bcd; logic tx; logic exp_tx;} row_t;
  row_t rows [4] = '{'{24'h021583, 1'b1, 1'b1}, '{24'h999999, 1'b0, 1'b0},
                     '{24'h000000, 1'b1, 1'b1}, '{24'h123456, 1'b0, 1'b0}};
  logic           clk = 1'b0;
  logic           reset = 1'b1;
  logic           has_reset_opt = 1'b1;
  logic           local_reset_en = 1'b1;
  logic [23:0]    total_bcd = 24'h021583;
  logic [23:0]    reset_bcd = 24'h000417;
  logic [7:0]     err_mask = 8'h00;
  logic           above_start = 1'b0;
  logic           energy_neg = 1'b0;
  logic           rx_msg = 1'b0;
  logic           tx_active = 1'b0;
  logic           energy_tick = 1'b0;
  wire logic      button;
  disp_pkg::lcd_t lcd;
  logic           energy_clear;
  logic           led;
  logic           pulse_out;
  int             errors = 0;
  int             comparisons = 0;
  int             cyc = 0;
  int             led_n = 0;
  int             s0_n = 0;
  int             clr_n = 0;

  always #50 clk = ~clk;

  user_panel u_panel (.clk(clk), .button(button));

  meter_display_ctrl #(.LONG_C(LONG_C), .TIMEOUT_C(TIMEOUT_C), .ENERGY_C(ENERGY_C),
    .ERR_C(ERR_C), .TEST_C(TEST_C), .ARROW_C(ARROW_C), .ANIM_C(ANIM_C), .COMM_C(COMM_C),
    .DENY_C(DENY_C), .DEB_C(DEB_C), .LED_C(LED_C), .S0_C(S0_C)) dut (
    .clk(clk), .reset(reset), .button(button), .has_reset_opt(has_reset_opt),
    .local_reset_en(local_reset_en), .total_bcd(total_bcd), .reset_bcd(reset_bcd),
    .err_mask(err_mask), .above_start(above_start), .energy_neg(energy_neg),
    .rx_msg(rx_msg), .tx_active(tx_active), .energy_tick(energy_tick), .lcd(lcd),
    .energy_clear(energy_clear), .led(led), .pulse_out(pulse_out));

  task automatic test_done();
    $display("Counts: comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Energy register side: clears the resettable count on request
  always @(posedge clk) begin
    cyc <= cyc + 1;
    led_n <= led_n + int'(led);
    s0_n <= s0_n + int'(pulse_out);
    clr_n <= clr_n + int'(energy_clear);
    if (energy_clear === 1'b1)
      reset_bcd <= 24'h000000;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end

  function automatic logic [41:0] disp_of(input logic [23:0] b);
    logic [41:0] r;
    for (int i = 0; i < 6; i++)
      r[i*7 +: 7] = SEGS[b[i*4 +: 4]];
    return r;
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task automatic chk_v(input string name, input logic [48:0] exp, input logic [48:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_n(input string name, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      errors++;
      $display("BAD %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  // Cycles that the current digit pattern stays unchanged
  task automatic measure(output int n);
    logic [41:0] d;
    n = 0;
    d = lcd.digit;
    while (lcd.digit === d && n < 200) begin
      step(1);
      n++;
    end
  endtask

  task automatic arrow_next(input logic [2:0] exp);
    logic [2:0] d;
    int         n;
    d = lcd.arrow;
    for (n = 0; n < ARROW_C + 3 && lcd.arrow === d; n++)
      step(1);
    chk_v("arrow", exp, lcd.arrow);
  endtask

  initial begin
    int k;
    int n;
    step(20);
    reset = 1'b0;
    step(2);
    chk_v("lamp", {{6{7'h7f}}, 1'b1, 3'h7, 3'h7}, lcd);
    step(TEST_C);
    chk_v("normal", {disp_of(total_bcd), 1'b0, 3'h7, 3'h0}, lcd);
    $display("done: power-up");
    foreach (rows[i]) begin
      total_bcd = rows[i].bcd;
      tx_active = rows[i].tx;
      step(3);
      chk_v("digits", disp_of(rows[i].bcd), lcd.digit);
      chk_v("tx", rows[i].exp_tx, lcd.tx);
    end
    $display("done: table");
    rx_msg = 1'b1;
    step(1);
    rx_msg = 1'b0;
    chk_v("rx", 1'b1, lcd.rx);
    step(COMM_C - 1);
    chk_v("rx_hold", 1'b1, lcd.rx);
    step(2);
    chk_v("rx_end", 1'b0, lcd.rx);
    above_start = 1'b1;
    step(2);
    chk_v("arrow", 3'h1, lcd.arrow);
    arrow_next(3'h2);
    arrow_next(3'h4);
    energy_neg = 1'b1;
    arrow_next(3'h2);
    arrow_next(3'h1);
    above_start = 1'b0;
    step(2);
    chk_v("arrow_idle", 3'h7, lcd.arrow);
    $display("done: status segments");
    u_panel.press(DEB_C + 5);
    step(2);
    chk_v("alt", {disp_of(reset_bcd), 1'b1}, {lcd.digit, lcd.tri_on});
    led_n = 0;
    s0_n = 0;
    energy_tick = 1'b1;
    step(10);
    energy_tick = 1'b0;
    step(10 * LED_C + 10);
    chk_n("led_cycles", 10 * LED_C, led_n);
    chk_n("s0_cycles", S0_C, s0_n);
    step(TIMEOUT_C - 80);
    chk_v("alt_held", 1'b1, lcd.tri_on);
    step(30);
    chk_v("timeout", 1'b0, lcd.tri_on);
    $display("done: short press");
    local_reset_en = 1'b0;
    u_panel.press(DEB_C + LONG_C + 4);
    chk_v("deny", 1'b1, lcd.deny);
    chk_n("no_clear", 0, clr_n);
    step(DENY_C + 2);
    chk_v("deny_end", 1'b0, lcd.deny);
    local_reset_en = 1'b1;
    fork
      u_panel.press(DEB_C + LONG_C + 8);
    join_none
    for (k = 0; k < 100 && energy_clear !== 1'b1; k++)
      step(1);
    chk_n("clear_at", 1, int'(k >= DEB_C + LONG_C && k <= DEB_C + LONG_C + 1));
    chk_v("anim", {SEGS[0], 35'h0}, lcd.digit);
    for (int p = 4; p >= 0; p--) begin
      for (k = 0; k < ANIM_C + 2 && lcd.digit[p] !== SEGS[0]; k++)
        step(1);
      chk_v("anim", 42'(SEGS[0]) << (7 * p), lcd.digit);
    end
    for (k = 0; k < ANIM_C + 3 && lcd.tri_on !== 1'b1; k++)
      step(1);
    chk_v("zeros", {disp_of(24'h0), 1'b1}, {lcd.digit, lcd.tri_on});
    step(10);
    chk_n("clears", 1, clr_n);
    $display("done: energy reset");
    step(TIMEOUT_C + 5);
    has_reset_opt = 1'b0;
    u_panel.press(DEB_C + 5);
    step(3);
    chk_v("no_alt", 1'b0, lcd.tri_on);
    has_reset_opt = 1'b1;
    err_mask = 8'h05;
    for (k = 0; k < ENERGY_C + 5 && lcd.digit[5] !== 7'h00; k++)
      step(1);
    chk_v("code1", {21'h0, SEGS[1], SEGS[0], SEGS[0]}, lcd.digit);
    measure(n);
    chk_n("code1_time", ERR_C, n);
    chk_v("code3", {21'h0, SEGS[3], SEGS[0], SEGS[0]}, lcd.digit);
    measure(n);
    chk_n("code3_time", ERR_C, n);
    chk_v("energy", disp_of(total_bcd), lcd.digit);
    measure(n);
    chk_n("energy_time", ENERGY_C, n);
    $display("done: error cycling");
    reset = 1'b1;
    step(2);
    chk_v("in_reset", 49'h0, lcd);
    reset = 1'b0;
    step(2);
    chk_v("lamp_again", {{6{7'h7f}}, 1'b1, 3'h7, 3'h7}, lcd);
    $display("done: second reset");
    test_done();
  end
endmodule
